// File: rtl/dpd_defines.vh
// register map, descriptor fields and codes of the descriptor decoder
`ifndef DPD_DEFINES_VH
`define DPD_DEFINES_VH
`define DPD_OFF_DESC 8'h00
`define DPD_OFF_EXT 8'h04
`define DPD_OFF_BASE 8'h08
`define DPD_OFF_GOFF 8'h0C
`define DPD_OFF_BOUND 8'h10
`define DPD_OFF_BLK0_LO 8'h14
`define DPD_OFF_BLK0_HI 8'h18
`define DPD_OFF_BLK1_LO 8'h1C
`define DPD_OFF_BLK1_HI 8'h20
`define DPD_OFF_CTRL 8'h24
`define DPD_OFF_CMD 8'h28
`define DPD_OFF_STATUS 8'h2C
`define DPD_OFF_ADDR 8'h30
`define DPD_OFF_SURF 8'h34
`define DPD_OFF_SS_BASE 8'h38
`define DPD_OFF_BL_BASE 8'h3C
`define DPD_OFF_ADDR2 8'h40
`define DPD_DESC_HDR 0
`define DPD_DESC_TYPE 5:1
`define DPD_DESC_PORT 7:6
`define DPD_DESC_SIMD16 8
`define DPD_DESC_IDX 16:9
`define DPD_CTRL_HWMODE 0
`define DPD_CTRL_TWOBLK 1
`define DPD_CTRL_MASK 15:8
`define DPD_IDX_STATELESS 8'hFF
`define DPD_IDX_SLM 8'hFE
`define DPD_IDX_BL_BINDLESS 8'hFC
`define DPD_IDX_SS_BINDLESS 8'hFB
`define DPD_IDX_RSV_HI 8'hFA
`define DPD_IDX_RSV_LO 8'hF0
`define DPD_PORT_P0 2'h0
`define DPD_PORT_P1 2'h1
`define DPD_PORT_RO 2'h2
`define DPD_PORT_RB 2'h3
`define DPD_NTYPE_P0 5'h09
`define DPD_NTYPE_P1 5'h13
`define DPD_NTYPE_RO 5'h06
`define DPD_NTYPE_RB 5'h03
`define DPD_T0_HWB_RD 5'h07
`define DPD_T0_HWB_WR 5'h08
`define DPD_T1_BLK_FIRST 5'h06
`define DPD_T1_BLK_LAST 5'h0A
`define DPD_T1_HWB_RD 5'h09
`define DPD_T1_HWB_WR 5'h0A
`define DPD_T1_WIDE_US_RD 5'h0D
`define DPD_T1_WIDE_US_WR 5'h0E
`define DPD_T1_TS_RD 5'h0F
`define DPD_T1_TS_WR 5'h10
`define DPD_TRO_RSI 5'h00
`define DPD_TRO_TS_UCW 5'h02
`define DPD_TRO_PAGE_OP 5'h04
`define DPD_TRO_TS_OP 5'h05
`define DPD_M_BOUND 3'h0
`define DPD_M_SLM 3'h1
`define DPD_M_ST32 3'h2
`define DPD_M_ST64 3'h3
`define DPD_M_BL_SS 3'h4
`define DPD_M_BL_BL 3'h5
`define DPD_M_RSV 3'h6
`define DPD_BOUND_MAX 4'hB
`define DPD_BOUND_SHIFT 6'h14
`endif

// File: rtl/dpd_index_sel.v
// surface index to address model classifier
`timescale 1ns/1ns
`include "dpd_defines.vh"
module dpd_index_sel (
    // descriptor view
    input wire [7:0] index,
    input wire wide,
    // classification
    output reg [2:0] model,
    output reg reserved
);
    always @* begin
        reserved = 1'b0;
        model = `DPD_M_BOUND;
        case (index)
            `DPD_IDX_STATELESS: model = wide ? `DPD_M_ST64 : `DPD_M_ST32;
            `DPD_IDX_SLM: model = `DPD_M_SLM;
            `DPD_IDX_SS_BINDLESS: model = `DPD_M_BL_SS;
            `DPD_IDX_BL_BINDLESS: model = `DPD_M_BL_BL;
            default: begin
                if (index >= `DPD_IDX_RSV_LO) begin
                    model = `DPD_M_RSV;
                    reserved = 1'b1;
                end
            end
        endcase
    end
endmodule

// File: rtl/dpd_decoder.v
// data port message descriptor decoder with avalon register slave
`timescale 1ns/1ns
`include "dpd_defines.vh"
module dpd_decoder (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // avalon-mm slave
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // decoded access
    output reg dec_valid_q,
    output reg dec_err_q,
    output reg mem_req_q,
    output reg [2:0] dec_model_q,
    output reg [63:0] mem_addr_q,
    output reg [2:0] payload_regs_q,
    output reg [7:0] chan_mask_q
);
    reg [31:0] desc_q;
    reg [31:0] ext_q;
    reg [31:0] base_q;
    reg [31:0] goff_q;
    reg [3:0] bound_q;
    reg [63:0] blk0_q;
    reg [63:0] blk1_q;
    reg [15:0] ctrl_q;
    reg [31:0] ss_base_q;
    reg [31:0] bl_base_q;
    reg done_q;
    reg oob_q;
    reg hwmode_q;
    reg [2:0] msg_regs_q;
    reg [31:0] surf_q;
    reg [63:0] addr2_q;
    reg [31:0] rdata_d;

    wire [4:0] mtype;
    wire [1:0] port;
    wire hdr;
    wire simd16;
    wire [7:0] idx;
    wire [2:0] model;
    wire idx_rsv;
    wire go;
    wire acc;
    wire [31:0] ctrl_wr;
    wire [31:0] status_w;

    assign hdr = desc_q[`DPD_DESC_HDR];
    assign mtype = desc_q[`DPD_DESC_TYPE];
    assign port = desc_q[`DPD_DESC_PORT];
    assign simd16 = desc_q[`DPD_DESC_SIMD16];
    assign idx = desc_q[`DPD_DESC_IDX];
    // accesses complete on the cycle waitrequest is low
    assign acc = ~avs_waitrequest & (avs_read | avs_write);
    assign go = acc & avs_write & (avs_address == `DPD_OFF_CMD);

    function [31:0] be_merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] be;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                be_merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
            end
        end
    endfunction

    // ctrl holds 16 bits, so the upper merged lanes are dropped
    assign ctrl_wr = be_merge({16'h0000, ctrl_q}, avs_writedata,
        avs_byteenable);
    // status fields packed from bit 0 upward
    assign status_w = {19'h00000, msg_regs_q, hwmode_q, oob_q,
        payload_regs_q, dec_model_q, dec_err_q, done_q};

    reg type_ok;
    reg wide;
    reg blkaddr;
    reg hword;
    reg typed;
    reg rsi;
    reg [31:0] base_eff;
    reg [31:0] goff_eff;
    reg [3:0] bound_eff;
    reg [32:0] addr32;
    reg [35:0] limit;
    reg oob;
    reg err;
    reg [2:0] pl_regs;
    reg [63:0] addr_d;
    reg [31:0] surf_d;
    reg [7:0] mask_d;
    reg hw_d;

    dpd_index_sel u_sel (
        .index(idx),
        .wide(wide),
        .model(model),
        .reserved(idx_rsv)
    );

    always @* begin
        case (port)
            `DPD_PORT_P0: type_ok = mtype < `DPD_NTYPE_P0;
            `DPD_PORT_P1: type_ok = mtype < `DPD_NTYPE_P1;
            `DPD_PORT_RO: type_ok = mtype < `DPD_NTYPE_RO;
            `DPD_PORT_RB: type_ok = mtype < `DPD_NTYPE_RB;
            default: type_ok = 1'b0;
        endcase
        blkaddr = ((port == `DPD_PORT_P1) & (mtype >= `DPD_T1_BLK_FIRST)
            & (mtype <= `DPD_T1_BLK_LAST))
            | ((port == `DPD_PORT_RO) & (mtype == `DPD_TRO_PAGE_OP));
        wide = ((port == `DPD_PORT_P1) & ((mtype <= `DPD_T1_BLK_LAST)
            | (mtype == `DPD_T1_WIDE_US_RD)
            | (mtype == `DPD_T1_WIDE_US_WR)))
            | ((port == `DPD_PORT_RO) & (mtype == `DPD_TRO_PAGE_OP));
        hword = ((port == `DPD_PORT_P0) & ((mtype == `DPD_T0_HWB_RD)
            | (mtype == `DPD_T0_HWB_WR)))
            | ((port == `DPD_PORT_P1) & ((mtype == `DPD_T1_HWB_RD)
            | (mtype == `DPD_T1_HWB_WR)));
        typed = ((port == `DPD_PORT_P1) & ((mtype == `DPD_T1_TS_RD)
            | (mtype == `DPD_T1_TS_WR)))
            | ((port == `DPD_PORT_RO) & ((mtype == `DPD_TRO_TS_UCW)
            | (mtype == `DPD_TRO_TS_OP)));
        rsi = (port == `DPD_PORT_RO) & (mtype == `DPD_TRO_RSI);

        // error on bad type or index
        err = ~type_ok | idx_rsv;
        if (hdr) begin
            base_eff = base_q;
            goff_eff = goff_q;
            bound_eff = bound_q;
        end else begin
            base_eff = 32'h00000000;
            goff_eff = 32'h00000000;
            bound_eff = `DPD_BOUND_MAX;
        end

        addr32 = {1'b0, base_eff} + {1'b0, goff_eff};
        // 36 bits so a bound code of 15 cannot wrap to zero
        limit = 36'h000000001 << ({2'b00, bound_eff} + `DPD_BOUND_SHIFT);
        if ((port == `DPD_PORT_RB) | blkaddr) begin
            // handles and block addresses carry no thread bound
            oob = 1'b0;
        end else begin
            oob = {3'b000, addr32} >= limit;
        end

        if (rsi | blkaddr) begin
            pl_regs = 3'h1;
        end else if (typed) begin
            pl_regs = simd16 ? 3'h5 : 3'h4;
        end else if (model == `DPD_M_ST64) begin
            pl_regs = simd16 ? 3'h4 : 3'h2;
        end else begin
            pl_regs = simd16 ? 3'h2 : 3'h1;
        end

        if (blkaddr) begin
            addr_d = blk0_q;
        end else begin
            addr_d = {32'h00000000, addr32[31:0]};
        end

        if (model == `DPD_M_BL_SS) begin
            surf_d = ss_base_q + ext_q;
        end else if (model == `DPD_M_BL_BL) begin
            surf_d = bl_base_q + ext_q;
        end else begin
            surf_d = 32'h00000000;
        end

        // hword mode widens slot 0 mask
        hw_d = hword & hdr & ctrl_q[`DPD_CTRL_HWMODE];
        if (hw_d) begin
            // one mask bit covers the whole slot in hword transfers
            mask_d = {8{ctrl_q[8]}};
        end else begin
            mask_d = ctrl_q[`DPD_CTRL_MASK];
        end
    end

    always @* begin
        case (avs_address)
            `DPD_OFF_DESC: rdata_d = desc_q;
            `DPD_OFF_EXT: rdata_d = ext_q;
            `DPD_OFF_BASE: rdata_d = base_q;
            `DPD_OFF_GOFF: rdata_d = goff_q;
            `DPD_OFF_BOUND: rdata_d = {28'h0000000, bound_q};
            `DPD_OFF_BLK0_LO: rdata_d = blk0_q[31:0];
            `DPD_OFF_BLK0_HI: rdata_d = blk0_q[63:32];
            `DPD_OFF_BLK1_LO: rdata_d = blk1_q[31:0];
            `DPD_OFF_BLK1_HI: rdata_d = blk1_q[63:32];
            `DPD_OFF_CTRL: rdata_d = {16'h0000, ctrl_q};
            `DPD_OFF_STATUS: rdata_d = status_w;
            `DPD_OFF_ADDR: rdata_d = mem_addr_q[31:0];
            `DPD_OFF_SURF: rdata_d = surf_q;
            `DPD_OFF_SS_BASE: rdata_d = ss_base_q;
            `DPD_OFF_BL_BASE: rdata_d = bl_base_q;
            `DPD_OFF_ADDR2: rdata_d = addr2_q[31:0];
            default: rdata_d = 32'h00000000;
        endcase
    end

    // one wait cycle per access keeps readdata registered
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            if (avs_waitrequest & (avs_read | avs_write)) begin
                avs_waitrequest <= 1'b0;
                avs_readdata <= avs_read ? rdata_d : 32'h00000000;
            end else begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            desc_q <= 32'h00000000;
            ext_q <= 32'h00000000;
            base_q <= 32'h00000000;
            goff_q <= 32'h00000000;
            bound_q <= `DPD_BOUND_MAX;
            blk0_q <= 64'h0000000000000000;
            blk1_q <= 64'h0000000000000000;
            ctrl_q <= 16'hFF00;
            ss_base_q <= 32'h00000000;
            bl_base_q <= 32'h00000000;
        end else if (acc & avs_write) begin
            case (avs_address)
                `DPD_OFF_DESC: desc_q <= be_merge(desc_q, avs_writedata,
                    avs_byteenable);
                `DPD_OFF_EXT: ext_q <= be_merge(ext_q, avs_writedata,
                    avs_byteenable);
                `DPD_OFF_BASE: base_q <= be_merge(base_q, avs_writedata,
                    avs_byteenable);
                `DPD_OFF_GOFF: goff_q <= be_merge(goff_q, avs_writedata,
                    avs_byteenable);
                `DPD_OFF_BOUND: begin
                    if (avs_byteenable[0]) begin
                        bound_q <= avs_writedata[3:0];
                    end
                end
                `DPD_OFF_BLK0_LO: blk0_q[31:0] <= be_merge(blk0_q[31:0],
                    avs_writedata, avs_byteenable);
                `DPD_OFF_BLK0_HI: blk0_q[63:32] <= be_merge(blk0_q[63:32],
                    avs_writedata, avs_byteenable);
                `DPD_OFF_BLK1_LO: blk1_q[31:0] <= be_merge(blk1_q[31:0],
                    avs_writedata, avs_byteenable);
                `DPD_OFF_BLK1_HI: blk1_q[63:32] <= be_merge(blk1_q[63:32],
                    avs_writedata, avs_byteenable);
                `DPD_OFF_CTRL: ctrl_q <= ctrl_wr[15:0];
                `DPD_OFF_SS_BASE: ss_base_q <= be_merge(ss_base_q,
                    avs_writedata, avs_byteenable);
                `DPD_OFF_BL_BASE: bl_base_q <= be_merge(bl_base_q,
                    avs_writedata, avs_byteenable);
                default: desc_q <= desc_q;
            endcase
        end
    end

    // decode is taken on the command write, one result per command
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_valid_q <= 1'b0;
            dec_err_q <= 1'b0;
            mem_req_q <= 1'b0;
            dec_model_q <= `DPD_M_BOUND;
            mem_addr_q <= 64'h0000000000000000;
            payload_regs_q <= 3'h0;
            chan_mask_q <= 8'h00;
            done_q <= 1'b0;
            oob_q <= 1'b0;
            hwmode_q <= 1'b0;
            msg_regs_q <= 3'h0;
            surf_q <= 32'h00000000;
            addr2_q <= 64'h0000000000000000;
        end else begin
            dec_valid_q <= go;
            mem_req_q <= go & ~err & ~oob;
            // classification is kept on error so software sees why
            if (go) begin
                done_q <= 1'b1;
                dec_err_q <= err;
                oob_q <= oob;
                dec_model_q <= model;
                mem_addr_q <= addr_d;
                payload_regs_q <= pl_regs;
                msg_regs_q <= pl_regs + {2'b00, hdr};
                chan_mask_q <= mask_d;
                hwmode_q <= hw_d;
                surf_q <= surf_d;
                addr2_q <= (blkaddr & ctrl_q[`DPD_CTRL_TWOBLK])
                    ? blk1_q : 64'h0000000000000000;
            end
        end
    end
endmodule

// File: test/dpd_decoder_assertions.sv
// assertions on the decoder's bus and decode ports
`timescale 1ns/1ns
module dpd_decoder_assertions (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // avalon-mm slave
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    // decoded access
    input wire dec_valid_q,
    input wire dec_err_q,
    input wire mem_req_q,
    input wire [2:0] dec_model_q,
    input wire [63:0] mem_addr_q,
    input wire [2:0] payload_regs_q
);
    wire req = avs_read || avs_write;
    wire cmd_done = avs_write && !avs_waitrequest && avs_address == 8'h28;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence s_pulse;
        dec_valid_q ##1 !dec_valid_q;
    endsequence

    AST_WAIT_ONE: assert property (req && avs_waitrequest |=> s_ack)
        else $error("access not answered after one wait cycle");
    AST_WAIT_IDLE: assert property (
        !req && avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest dropped without a request");
    AST_CMD_PULSE: assert property (cmd_done |=> s_pulse)
        else $error("command write gave no one-cycle decode pulse");
    AST_VALID_CAUSE: assert property (
        dec_valid_q |-> $past(cmd_done))
        else $error("decode pulse without a command write");
    AST_REQ_OK: assert property (
        mem_req_q |-> dec_valid_q && !dec_err_q)
        else $error("access issued outside a clean decode");
    AST_PAYLOAD: assert property (
        dec_valid_q |-> payload_regs_q inside {3'h1, 3'h2, 3'h4, 3'h5})
        else $error("payload size outside 1, 2, 4 or 5");
    AST_MODEL: assert property (
        dec_valid_q && !dec_err_q |-> dec_model_q != 3'h6)
        else $error("reserved model without error flag");
    AST_HOLD: assert property (!cmd_done |=> $stable(dec_model_q) &&
        $stable(mem_addr_q) && $stable(payload_regs_q))
        else $error("decode outputs moved without a command");
endmodule

bind dpd_decoder dpd_decoder_assertions chk_u (.ref_clk, .rst_n,
    .avs_address, .avs_read, .avs_write, .avs_waitrequest, .dec_valid_q,
    .dec_err_q, .mem_req_q, .dec_model_q, .mem_addr_q, .payload_regs_q);

// File: test/dpd_thread_model.sv
// requester model: a thread sending descriptors over avalon
`timescale 1ns/1ns
module dpd_thread_model (
    // clock
    input wire ref_clk,
    // avalon-mm master side
    output reg [7:0] avs_address,
    output reg avs_read,
    output reg avs_write,
    output reg [31:0] avs_writedata,
    output reg [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest
);
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
    end

    // released lines invert so stale values never pass
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~d;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        access(1'b1, a, d, q);
    endtask

    // header bit and type in each descriptor
    task automatic send(input logic h, input logic [4:0] t,
                        input logic [1:0] p, input logic s,
                        input logic [7:0] i);
        wr(8'h00, {15'h0, i, s, p, t, h});
        wr(8'h28, 32'h0);
    endtask
endmodule

// File: test/dpd_decoder_tb.sv
// self-checking bench of the descriptor decoder
`timescale 1ns/1ns
module dpd_decoder_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    wire [7:0] avs_address, chan_mask_q;
    wire avs_read, avs_write, avs_waitrequest;
    wire [31:0] avs_writedata, avs_readdata;
    wire [3:0] avs_byteenable;
    wire dec_valid_q, dec_err_q, mem_req_q;
    wire [2:0] dec_model_q, payload_regs_q;
    wire [63:0] mem_addr_q;
    int bad_count = 0;
    int compares = 0;

    always #4 ref_clk = ~ref_clk;

    dpd_decoder dut_u (.ref_clk, .rst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .dec_valid_q, .dec_err_q, .mem_req_q,
        .dec_model_q, .mem_addr_q, .payload_regs_q, .chan_mask_q);
    dpd_thread_model th_u (.ref_clk, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);

    task automatic chk(input string n, input logic [63:0] e,
                       input logic [63:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %0h, seen %0h", n, e, g);
        end
    endtask
    task automatic rc(input string n, input logic [7:0] a,
                      input logic [63:0] e);
        logic [31:0] q;
        th_u.access(1'b0, a, 32'h0, q);
        chk(n, e, q);
    endtask
    task automatic go(input logic h, input logic [4:0] t,
                      input logic [1:0] p, input logic s,
                      input logic [7:0] i);
        th_u.send(h, t, p, s, i);
        #1;
        chk("valid", 1, dec_valid_q);
    endtask

    task automatic t_regs();
        rc("bound", 8'h10, 32'hB);
        rc("ctrl", 8'h24, 32'h0000FF00);
        th_u.wr(8'h2C, 32'hFFFFFFFF);
        rc("status", 8'h2C, 32'h0);
        rc("unmapped", 8'h44, 32'h0);
    endtask
    task automatic t_types();
        logic [4:0] n [4] = '{5'h09, 5'h13, 5'h06, 5'h03};
        for (int p = 0; p < 4; p++) begin
            for (int t = 0; t <= n[p]; t++) begin
                go(0, t[4:0], p[1:0], 0, 8'hFF);
                chk("err", t == n[p], dec_err_q);
                chk("req", t != n[p], mem_req_q);
            end
        end
    endtask
    task automatic t_index();
        logic [7:0] ix [6] = '{8'hFE, 8'hFF, 8'hFF, 8'hFB, 8'hFC, 8'h05};
        logic [2:0] md [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
        th_u.wr(8'h04, 32'h40);
        th_u.wr(8'h38, 32'h1000);
        th_u.wr(8'h3C, 32'h2000);
        for (int k = 0; k < 6; k++) begin
            go(0, (k == 2) ? 5'h00 : 5'h0B, 2'h1, 0, ix[k]);
            chk("model", md[k], dec_model_q);
            if (k == 3) rc("surf_ss", 8'h34, 32'h1040);
            if (k == 4) rc("surf_bl", 8'h34, 32'h2040);
        end
        // reserved indices are sent on purpose here
        for (int i = 240; i < 254; i++) begin
            if (i == 251 || i == 252) continue;
            go(1, 5'h0B, 2'h1, 0, i[7:0]);
            chk("rsv_err", 1, dec_err_q);
            chk("rsv_req", 0, mem_req_q);
        end
    endtask
    task automatic t_defaults();
        th_u.wr(8'h08, 32'h100);
        th_u.wr(8'h0C, 32'h20);
        th_u.wr(8'h10, 32'h0);
        go(0, 5'h00, 2'h0, 0, 8'hFF);
        chk("addr_nohdr", 64'h0, mem_addr_q);
        chk("req_nohdr", 1, mem_req_q);
        go(1, 5'h00, 2'h0, 0, 8'hFF);
        chk("addr_hdr", 64'h120, mem_addr_q);
        th_u.wr(8'h0C, 32'hFFF00);
        go(1, 5'h00, 2'h0, 0, 8'hFF);
        chk("req_oob", 0, mem_req_q);
        th_u.wr(8'h0C, 32'hFFEFF);
        go(1, 5'h00, 2'h0, 0, 8'hFF);
        chk("req_edge", 1, mem_req_q);
        go(0, 5'h0B, 2'h1, 0, 8'hFE);
        chk("slm_nohdr", 64'h0, mem_addr_q);
        go(1, 5'h0B, 2'h1, 0, 8'hFE);
        chk("slm_hdr", 64'hFFFFF, mem_addr_q);
        // bound code 15 gives a limit of 2^35, so 0xFFFFF is in range
        th_u.wr(8'h10, 32'hF);
        go(1, 5'h00, 2'h0, 0, 8'hFF);
        chk("req_wide_bound", 1, mem_req_q);
        th_u.wr(8'h10, 32'hB);
    endtask
    task automatic t_block();
        th_u.wr(8'h14, 32'h23456780);
        th_u.wr(8'h18, 32'h1);
        th_u.wr(8'h1C, 32'hABCD0000);
        th_u.wr(8'h24, 32'h0000FF02);
        go(1, 5'h06, 2'h1, 0, 8'hFF);
        chk("blk0", 64'h123456780, mem_addr_q);
        rc("blk1", 8'h40, 32'hABCD0000);
        th_u.wr(8'h24, 32'h0000FF00);
        go(1, 5'h06, 2'h1, 0, 8'hFF);
        rc("blk1_off", 8'h40, 32'h0);
    endtask
    task automatic t_hword();
        logic [31:0] cv [5] = '{32'h101, 32'h101, 32'hFE01, 32'hFE00,
            32'h101};
        logic [4:0] ty [5] = '{5'h07, 5'h09, 5'h08, 5'h08, 5'h07};
        logic [7:0] mk [5] = '{8'hFF, 8'hFF, 8'h00, 8'hFE, 8'h01};
        // the last entry has no header, so hword mode stays off
        for (int k = 0; k < 5; k++) begin
            th_u.wr(8'h24, cv[k]);
            go(k != 4, ty[k], (k == 1) ? 2'h1 : 2'h0, 0, 8'hFF);
            chk("chan_mask", mk[k], chan_mask_q);
        end
    endtask
    task automatic t_payload();
        logic [4:0] ty [7] = '{0, 0, 0, 0, 15, 15, 0};
        logic [1:0] po [7] = '{0, 0, 1, 1, 1, 1, 2};
        logic [2:0] pl [7] = '{1, 2, 2, 4, 4, 5, 1};
        logic [31:0] q;
        for (int k = 0; k < 7; k++) begin
            go(k == 1, ty[k], po[k], k[0], (k >= 4) ? 8'h05 : 8'hFF);
            chk("payload", pl[k], payload_regs_q);
            th_u.access(1'b0, 8'h2C, 32'h0, q);
            chk("msg_regs", pl[k] + (k == 1), q[12:10]);
        end
    endtask

    task automatic finish_test();
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_types();
        t_index();
        t_defaults();
        t_block();
        t_hword();
        t_payload();
        finish_test();
    end

    // run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        finish_test();
    end
endmodule
